// ### ilcd_pkg.sv
// Contract
// - pulse reset clears mismatch estimator, correction state and output link (code keeps correction control; disable flags reload from it)
// - host writes 0x08 to correction control; device stops that channel's correction (code applies it only with validity at 0x04 and on the next pulse reset)
// - host writes 0x01 then 0x00 to pulse reset: assert then release
// - disabled correction outputs raw samples with mismatch uncorrected
// - estimator tracks drift while unfrozen and holds parameters while frozen (code still clears them to zero on pulse reset while frozen)
package ilcd_pkg;
  localparam logic [15:0] ADDR_PAGE0      = 16'h4001;
  localparam logic [15:0] ADDR_PAGE1      = 16'h4002;
  localparam logic [15:0] ADDR_PAGE2      = 16'h4003;
  localparam logic [15:0] ADDR_PAGE3      = 16'h4004;
  localparam logic [15:0] ADDR_WMODE      = 16'h4005;
  localparam logic [15:0] ADDR_PULSE_RST  = 16'h6000;
  localparam logic [15:0] ADDR_CORR_A     = 16'h6040;
  localparam logic [15:0] ADDR_VALID_A    = 16'h604B;
  localparam logic [15:0] ADDR_CORR_B     = 16'h7040;
  localparam logic [15:0] ADDR_VALID_B    = 16'h704B;
  localparam logic [7:0]  PAGE_CORR       = 8'h68;
  localparam logic [7:0]  VALID_DISABLE   = 8'h04;
  localparam int          CORR_DIS_BIT    = 3;
  localparam int          PULSE_BIT       = 0;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam int          EST_STEP_SHIFT  = 4;
endpackage

// ### ilcd_channel.sv
`timescale 1ns/10ps
module ilcd_channel #(
  parameter int W = 14
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         corr_disable,
  input  wire logic         freeze,
  input  wire logic [W-1:0] even_in,
  input  wire logic [W-1:0] odd_in,
  output logic      [W-1:0] even_out,
  output logic      [W-1:0] odd_out
);
  logic signed [W-1:0] est_r;
  logic signed [W-1:0] est_nxt;
  logic        [W-1:0] even_r;
  logic        [W-1:0] odd_r;
  logic        [W-1:0] even_nxt;
  logic        [W-1:0] odd_nxt;
  logic signed [W-1:0] diff;

  always_comb begin
    diff    = $signed(odd_in) - $signed(even_in);
    est_nxt = est_r;
    if (clear) begin
      est_nxt = '0;
    end else if (!freeze) begin
      // slow leaky tracking follows drift
      est_nxt = est_r + ((diff - est_r) >>> ilcd_pkg::EST_STEP_SHIFT);
    end
    even_nxt = even_in;
    odd_nxt  = corr_disable ? odd_in : W'($signed(odd_in) - (est_r >>> 1));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      est_r  <= '0;
      even_r <= '0;
      odd_r  <= '0;
    end else begin
      est_r  <= est_nxt;
      even_r <= even_nxt;
      odd_r  <= odd_nxt;
    end
  end

  assign even_out = even_r;
  assign odd_out  = odd_r;
endmodule

// ### ilcd_top.sv
`timescale 1ns/10ps
module ilcd_top #(
  parameter int W = 14
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic         rd_en,
  input  wire logic [15:0]  addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         freeze,
  input  wire logic [W-1:0] a_even_in,
  input  wire logic [W-1:0] a_odd_in,
  input  wire logic [W-1:0] b_even_in,
  input  wire logic [W-1:0] b_odd_in,
  output logic      [7:0]   rdata,
  output logic              link_reset,
  output logic              channel_a_corr_off,
  output logic              channel_b_corr_off,
  output logic      [W-1:0] a_even_out,
  output logic      [W-1:0] a_odd_out,
  output logic      [W-1:0] b_even_out,
  output logic      [W-1:0] b_odd_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] page_r [4];
  logic [7:0] page_nxt [4];
  logic [7:0] wmode_r, wmode_nxt;
  logic [7:0] prst_r, prst_nxt;
  logic [7:0] corr_a_r, corr_a_nxt;
  logic [7:0] corr_b_r, corr_b_nxt;
  logic [7:0] val_a_r, val_a_nxt;
  logic [7:0] val_b_r, val_b_nxt;
  logic [7:0] rdata_nxt;
  logic       off_a_r, off_a_nxt;
  logic       off_b_r, off_b_nxt;
  logic       lrst_r;
  logic       paged;
  logic       pulse;

  // correction page only decodes once selected; broadcast reaches both channels
  assign paged = page_r[3] == ilcd_pkg::PAGE_CORR && page_r[2] == 8'h00
                 && page_r[1] == 8'h00 && page_r[0] == 8'h00;
  assign pulse = prst_r[ilcd_pkg::PULSE_BIT];

  always_comb begin
    page_nxt   = page_r;
    wmode_nxt  = wmode_r;
    prst_nxt   = prst_r;
    corr_a_nxt = corr_a_r;
    corr_b_nxt = corr_b_r;
    val_a_nxt  = val_a_r;
    val_b_nxt  = val_b_r;
    if (wr_en) begin
      case (addr)
        ilcd_pkg::ADDR_PAGE0:     page_nxt[0] = wdata;
        ilcd_pkg::ADDR_PAGE1:     page_nxt[1] = wdata;
        ilcd_pkg::ADDR_PAGE2:     page_nxt[2] = wdata;
        ilcd_pkg::ADDR_PAGE3:     page_nxt[3] = wdata;
        ilcd_pkg::ADDR_WMODE:     wmode_nxt   = wdata;
        ilcd_pkg::ADDR_PULSE_RST: prst_nxt    = wdata;
        ilcd_pkg::ADDR_VALID_A: begin
          if (paged) val_a_nxt = wdata;
          if (paged && wmode_r != 8'h00) val_b_nxt = wdata;
        end
        ilcd_pkg::ADDR_VALID_B: begin
          if (paged) val_b_nxt = wdata;
          if (paged && wmode_r != 8'h00) val_a_nxt = wdata;
        end
        ilcd_pkg::ADDR_CORR_A: begin
          if (paged) corr_a_nxt = wdata;
          if (paged && wmode_r != 8'h00) corr_b_nxt = wdata;
        end
        ilcd_pkg::ADDR_CORR_B: begin
          if (paged) corr_b_nxt = wdata;
          if (paged && wmode_r != 8'h00) corr_a_nxt = wdata;
        end
        default: ;
      endcase
    end
  end

  // disable takes effect only if validity armed; latched while pulse reset is asserted
  always_comb begin
    off_a_nxt = off_a_r;
    off_b_nxt = off_b_r;
    if (pulse) begin
      off_a_nxt = val_a_r == ilcd_pkg::VALID_DISABLE
                  && corr_a_r[ilcd_pkg::CORR_DIS_BIT];
      off_b_nxt = val_b_r == ilcd_pkg::VALID_DISABLE
                  && corr_b_r[ilcd_pkg::CORR_DIS_BIT];
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_en) begin
      case (addr)
        ilcd_pkg::ADDR_PAGE0:     rdata_nxt = page_r[0];
        ilcd_pkg::ADDR_PAGE1:     rdata_nxt = page_r[1];
        ilcd_pkg::ADDR_PAGE2:     rdata_nxt = page_r[2];
        ilcd_pkg::ADDR_PAGE3:     rdata_nxt = page_r[3];
        ilcd_pkg::ADDR_WMODE:     rdata_nxt = wmode_r;
        ilcd_pkg::ADDR_PULSE_RST: rdata_nxt = prst_r;
        ilcd_pkg::ADDR_VALID_A:   rdata_nxt = paged ? val_a_r : 8'h00;
        ilcd_pkg::ADDR_VALID_B:   rdata_nxt = paged ? val_b_r : 8'h00;
        ilcd_pkg::ADDR_CORR_A:    rdata_nxt = paged ? corr_a_r : 8'h00;
        ilcd_pkg::ADDR_CORR_B:    rdata_nxt = paged ? corr_b_r : 8'h00;
        default:                  rdata_nxt = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        page_r[i] <= ilcd_pkg::REG_RESET;
      end
      wmode_r  <= ilcd_pkg::REG_RESET;
      prst_r   <= ilcd_pkg::REG_RESET;
      corr_a_r <= ilcd_pkg::REG_RESET;
      corr_b_r <= ilcd_pkg::REG_RESET;
      val_a_r  <= ilcd_pkg::REG_RESET;
      val_b_r  <= ilcd_pkg::REG_RESET;
      rdata    <= 8'h00;
      off_a_r  <= 1'b0;
      off_b_r  <= 1'b0;
      lrst_r   <= 1'b0;
    end else begin
      page_r   <= page_nxt;
      wmode_r  <= wmode_nxt;
      prst_r   <= prst_nxt;
      corr_a_r <= corr_a_nxt;
      corr_b_r <= corr_b_nxt;
      val_a_r  <= val_a_nxt;
      val_b_r  <= val_b_nxt;
      rdata    <= rdata_nxt;
      off_a_r  <= off_a_nxt;
      off_b_r  <= off_b_nxt;
      lrst_r   <= pulse;
    end
  end

  assign link_reset         = lrst_r;
  assign channel_a_corr_off = off_a_r;
  assign channel_b_corr_off = off_b_r;

  ////////////////////////////////////////////////////////////////////////////
  ilcd_channel #(.W(W)) u_chan_a (
    .clock        (clock),
    .rst          (rst),
    .clear        (pulse),
    .corr_disable (off_a_r),
    .freeze       (freeze),
    .even_in      (a_even_in),
    .odd_in       (a_odd_in),
    .even_out     (a_even_out),
    .odd_out      (a_odd_out)
  );

  ilcd_channel #(.W(W)) u_chan_b (
    .clock        (clock),
    .rst          (rst),
    .clear        (pulse),
    .corr_disable (off_b_r),
    .freeze       (freeze),
    .even_in      (b_even_in),
    .odd_in       (b_odd_in),
    .even_out     (b_even_out),
    .odd_out      (b_odd_out)
  );
endmodule

// ### ilcd_checker.sv
`timescale 1ns/10ps
module ilcd_checker #(parameter int W = 14) (
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         wr_en,
  input wire logic [15:0]  addr,
  input wire logic [7:0]   wdata,
  input wire logic         freeze,
  input wire logic [W-1:0] a_odd_in,
  input wire logic         link_reset,
  input wire logic         channel_a_corr_off,
  input wire logic [W-1:0] a_odd_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [W-1:0] odd_r;
  logic [W-1:0] gap;
  // gap is the correction actually applied to the odd sample
  always_ff @(posedge clock) odd_r <= a_odd_in;
  assign gap = odd_r - a_odd_out;
  sequence pulse_on;
    wr_en && addr == ilcd_pkg::ADDR_PULSE_RST && wdata[ilcd_pkg::PULSE_BIT];
  endsequence
  a_pulse_link: assert property (pulse_on |=> ##1 link_reset)
    else $error("no link reset after pulse");
  a_off_at_pulse: assert property ($changed(channel_a_corr_off) |-> link_reset)
    else $error("disable moved outside pulse");
  a_raw_out: assert property (channel_a_corr_off [*2] |-> gap == '0)
    else $error("correction while disabled");
  a_clear_est: assert property (link_reset [*2] |-> gap == '0)
    else $error("estimate kept over pulse");
  a_frozen_hold: assert property ((freeze && !link_reset) [*3] |-> $stable(gap))
    else $error("estimate moved while frozen");
endmodule
//////////////////////////////
bind ilcd_top ilcd_checker #(.W(W)) i_chk (.clock, .rst, .wr_en, .addr, .wdata, .freeze,
  .a_odd_in, .link_reset, .channel_a_corr_off, .a_odd_out);

// ### ilcd_host.sv
`timescale 1ns/10ps
module ilcd_host (
  input  wire logic        clock,
  input  wire logic [7:0]  rdata,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [15:0] addr,
  output logic      [7:0]  wdata
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    // released bus shows no stale value
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  // pulse reset comes last so the estimator restarts clean
  task automatic disable_seq();
    wr(ilcd_pkg::ADDR_WMODE, 8'h00);
    wr(ilcd_pkg::ADDR_PAGE3, ilcd_pkg::PAGE_CORR);
    wr(ilcd_pkg::ADDR_PAGE2, 8'h00);
    wr(ilcd_pkg::ADDR_PAGE1, 8'h00);
    wr(ilcd_pkg::ADDR_PAGE0, 8'h00);
    wr(ilcd_pkg::ADDR_VALID_A, ilcd_pkg::VALID_DISABLE);
    wr(ilcd_pkg::ADDR_VALID_B, ilcd_pkg::VALID_DISABLE);
    wr(ilcd_pkg::ADDR_CORR_A, 8'h08);
    wr(ilcd_pkg::ADDR_CORR_B, 8'h08);
    wr(ilcd_pkg::ADDR_PULSE_RST, 8'h01);
    wr(ilcd_pkg::ADDR_PULSE_RST, 8'h00);
  endtask
endmodule

// ### test_interleave_correction_disable.sv
`timescale 1ns/10ps
module test_interleave_correction_disable;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        freeze = 1'b0;
  logic        wr_en, rd_en, link_reset, a_off, b_off;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, rv;
  logic [13:0] cnt = '0, off = 14'h0028, prev, aoo;
  logic [13:0] cnt_d, aeo, beo, boo;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #4 clock = ~clock;
  always @(posedge clock) cnt <= cnt + 14'h0003;
  always @(posedge clock) prev <= cnt + off;
  always @(posedge clock) cnt_d <= cnt;
  ilcd_top i_ilcd_top (.clock, .rst, .wr_en, .rd_en, .addr, .wdata, .freeze, .a_even_in(cnt),
    .a_odd_in(cnt + off), .b_even_in(cnt + off), .b_odd_in(cnt), .rdata, .link_reset,
    .channel_a_corr_off(a_off), .channel_b_corr_off(b_off), .a_even_out(aeo), .a_odd_out(aoo),
    .b_even_out(beo), .b_odd_out(boo));
  ilcd_host host (.clock, .rdata, .wr_en, .rd_en, .addr, .wdata);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////
  // tests need about 2 us
  initial begin
    #50us;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    host.wr(16'h5000, 8'hA5);
    host.rd(16'h5000, rv);
    chk("unmapped", rv, 8'h00);
    host.wr(16'h604B, 8'h04);
    host.rd(16'h604B, rv);
    chk("page gate", rv, 8'h00);
    host.wr(16'h4005, 8'h01);
    host.wr(16'h4004, 8'h68);
    host.wr(16'h604B, 8'h04);
    host.rd(16'h704B, rv);
    chk("broadcast", rv, 8'h04);
    host.wr(16'h7040, 8'h08);
    host.rd(16'h6040, rv);
    chk("broadcast b", rv, 8'h08);
    host.rd(16'h4004, rv);
    chk("page read", rv, 8'h68);
    $display("test 1 done");
    host.disable_seq();
    repeat (3) @(negedge clock);
    chk("off a", a_off, 1'b1);
    chk("off b", b_off, 1'b1);
    chk("link low", link_reset, 1'b0);
    repeat (4) @(negedge clock) begin
      chk("raw a", aoo, prev);
      chk("raw b", boo, cnt_d);
      chk("even a", aeo, cnt_d);
      chk("even b", beo, prev);
    end
    $display("test 2 done");
    host.wr(16'h6040, 8'h00);
    host.wr(16'h6000, 8'h01);
    host.wr(16'h6000, 8'h00);
    repeat (60) @(negedge clock);
    chk("on a", a_off, 1'b0);
    chk("tracked", prev - aoo, 14'h000C);
    @(posedge clock);
    freeze <= 1'b1;
    off <= 14'h0100;
    repeat (20) @(negedge clock);
    chk("frozen", prev - aoo, 14'h000C);
    $display("test 3 done");
    host.wr(16'h6000, 8'h01);
    repeat (3) @(negedge clock);
    chk("link high", link_reset, 1'b1);
    chk("cleared", prev - aoo, 14'h0000);
    host.wr(16'h6000, 8'h00);
    host.rd(16'h7040, rv);
    chk("ctrl b", rv, 8'h08);
    $display("test 4 done");
    // estimate was cleared while frozen; tracking must start again from zero
    @(posedge clock);
    freeze <= 1'b0;
    repeat (100) @(negedge clock);
    chk("retracked", prev - aoo, 14'h0078);
    $display("test 5 done");
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("reset off b", b_off, 1'b0);
    chk("reset link", link_reset, 1'b0);
    host.rd(16'h4004, rv);
    chk("reset page", rv, 8'h00);
    $display("test 6 done");
    give_verdict();
  end
endmodule
